// ---- bench/msrc_board.sv ----
`timescale 1ns/1ps
module msrc_board #(
    parameter int POR_HOLD = 20,
    parameter int LOCK_DLY = 40
) (
    // clock and bench reset
    input wire logic i_clk,
    input wire logic i_rst,
    // device drives and external pulls
    input wire logic i_hard_oe,
    input wire logic i_soft_oe,
    input wire logic i_pll_rst,
    input wire logic i_ext_hard,
    input wire logic i_ext_soft,
    // board levels
    output logic o_por_n,
    output logic o_hard_n,
    output logic o_soft_n,
    output logic o_lock
);
    int pc_ff;
    int lc_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_ff <= 0;
            lc_ff <= 0;
        end else begin
            pc_ff <= (pc_ff < POR_HOLD) ? pc_ff + 1 : pc_ff;
            lc_ff <= i_pll_rst ? 0 : ((lc_ff < LOCK_DLY) ? lc_ff + 1 : lc_ff);
        end
    end
    assign o_por_n = (pc_ff >= POR_HOLD);
    assign o_lock = (lc_ff >= LOCK_DLY);
    // pull-ups: either party may only pull low
    assign o_hard_n = !(i_hard_oe || i_ext_hard);
    assign o_soft_n = !(i_soft_oe || i_ext_soft);
endmodule // msrc_board

// ---- bench/msrc_chk.sv ----
`timescale 1ns/1ps
module msrc_chk
    import msrc_pkg::*;
(
    // clock, reset, power-on pin
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_power_on_reset_n,
    // reset pins
    input wire logic o_hard_reset_n,
    input wire logic o_hard_reset_n_oe,
    input wire logic o_soft_reset_n,
    input wire logic o_soft_reset_n_oe,
    // latched configuration
    input wire logic [CFG_W-1:0] o_por_cfg,
    input wire logic [HRCW_W-1:0] o_hrcw,
    // reset outputs
    input wire logic o_por_internal,
    input wire logic o_system_pll_rst,
    input wire logic o_system_integration_unit_rst,
    input wire logic o_peripheral_bus_rst,
    input wire logic o_core_rst,
    input wire logic o_multicore_bus_system_rst
);
    // 12 bits hold the longest power-on stretch of this bench
    logic [11:0] hcnt_ff;
    logic [11:0] pcnt_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hcnt_ff <= '0;
            pcnt_ff <= '0;
        end else begin
            hcnt_ff <= o_hard_reset_n_oe ? hcnt_ff + 1'b1 : '0;
            pcnt_ff <= (i_power_on_reset_n && o_por_internal) ?
                pcnt_ff + 1'b1 : '0;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_soft_tail;
        o_soft_reset_n_oe [*3] ##1 !o_soft_reset_n_oe;
    endsequence
    property p_hard_soft;
        o_hard_reset_n_oe |-> o_soft_reset_n_oe;
    endproperty
    a_hard_soft: assert property (p_hard_soft)
        else $error("hard pin driven without soft pin");
    property p_od;
        !o_hard_reset_n && !o_soft_reset_n;
    endproperty
    a_od: assert property (p_od)
        else $error("reset pin driven high");
    property p_por_all;
        o_por_internal |-> o_system_pll_rst && o_hard_reset_n_oe
            && o_soft_reset_n_oe && o_core_rst;
    endproperty
    a_por_all: assert property (p_por_all)
        else $error("power-on reset incomplete");
    property p_pll;
        o_system_pll_rst |-> o_por_internal;
    endproperty
    a_pll: assert property (p_pll)
        else $error("pll reset outside power-on");
    property p_hard_siu;
        o_hard_reset_n_oe |-> o_system_integration_unit_rst;
    endproperty
    a_hard_siu: assert property (p_hard_siu)
        else $error("hard pin without unit reset");
    property p_siu_all;
        o_system_integration_unit_rst |-> o_core_rst
            && o_peripheral_bus_rst && o_multicore_bus_system_rst;
    endproperty
    a_siu_all: assert property (p_siu_all)
        else $error("core or bus reset missing");
    property p_por_dly;
        $fell(o_por_internal) |-> pcnt_ff >= 1024 && pcnt_ff <= 1030;
    endproperty
    a_por_dly: assert property (p_por_dly)
        else $error("power-on release delay wrong");
    property p_hard_len;
        $fell(o_hard_reset_n_oe) |-> hcnt_ff >= 512;
    endproperty
    a_hard_len: assert property (p_hard_len)
        else $error("hard pin released early");
    property p_soft_tail;
        $fell(o_hard_reset_n_oe) |-> s_soft_tail;
    endproperty
    a_soft_tail: assert property (p_soft_tail)
        else $error("soft pin not released 3 cycles after hard");
    property p_por_cfg;
        $changed(o_por_cfg) |-> o_por_internal;
    endproperty
    a_por_cfg: assert property (p_por_cfg)
        else $error("straps changed outside power-on");
    property p_hrcw;
        $changed(o_hrcw) |-> o_system_integration_unit_rst;
    endproperty
    a_hrcw: assert property (p_hrcw)
        else $error("config word changed outside hard reset");
    property p_keep_cfg;
        o_core_rst && !o_system_integration_unit_rst |->
            $stable(o_hrcw) && $stable(o_por_cfg);
    endproperty
    a_keep_cfg: assert property (p_keep_cfg)
        else $error("soft reset altered configuration");
endmodule // msrc_chk
bind msrc_top msrc_chk i_msrc_chk (.*);

// ---- bench/test_msrc_top.sv ----
`timescale 1ns/1ps
module test_msrc_top;
    import msrc_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic e, por_n, hard_n, soft_n, lock, hoe, soe, pllr, core, ehard, esoft;
    logic wdog, bmon, tap, tdrv;
    logic [CFG_W-1:0] cfg, pcfg;
    logic [HRCW_W-1:0] hrcw, phrcw;
    int errors, samples_checked;
    msrc_top i_msrc_top (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_power_on_reset_n(por_n),
        .i_hard_reset_n(hard_n), .o_hard_reset_n(), .o_hard_reset_n_oe(hoe),
        .i_soft_reset_n(soft_n), .o_soft_reset_n(), .o_soft_reset_n_oe(soe),
        .i_wdog_expired(wdog), .i_bmon_expired(bmon), .i_tap_reset_cmd(tap),
        .i_tap_drive_pin(tdrv), .i_system_pll_lock(lock), .i_cfg_pins(cfg),
        .i_hrcw(hrcw), .o_por_cfg(pcfg), .o_hrcw(phrcw), .o_por_internal(),
        .o_system_pll_rst(pllr), .o_system_integration_unit_rst(),
        .o_peripheral_bus_rst(), .o_core_rst(core),
        .o_multicore_bus_system_rst());
    msrc_board i_msrc_board (.i_clk(clk), .i_rst(rst), .i_hard_oe(hoe),
        .i_soft_oe(soe), .i_pll_rst(pllr), .i_ext_hard(ehard),
        .i_ext_soft(esoft), .o_por_n(por_n), .o_hard_n(hard_n),
        .o_soft_n(soft_n), .o_lock(lock));
    task summarize;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        samples_checked++;
        if (seen !== ex) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    // setup, then access until pready; released only after that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            summarize();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // s: 0 ext hard, 1 ext soft, 2 wdog, 3 bmon, 4/5 tap, 6 wdog+soft pin
    task fire(input int s, input logic [5:0] st);
        int n;
        logic hs, ss;
        @(posedge clk);
        ehard <= (s == 0);
        esoft <= (s == 1);
        wdog <= (s == 2 || s == 6);
        bmon <= (s == 3);
        tap <= (s == 4 || s == 5);
        tdrv <= (s == 5);
        repeat (5) @(posedge clk);
        {ehard, esoft, wdog, bmon, tap, tdrv} <= 6'h00;
        hs = 0;
        ss = 0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            hs |= hoe;
            ss |= soe;
            if (s == 6) esoft <= (n >= 100 && n < 104);
        end while (core === 1'b1 && n < 800);
        if (n >= 800) begin
            errors++;
            summarize();
        end
        repeat (10) @(posedge clk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", r, {26'h0, st});
        chk("hard pin", hs, s == 0 || s == 2 || s == 3 || s == 6);
        chk("soft pin", ss, s != 4);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        errors = 0;
        samples_checked = 0;
        {rst, psel, penable, pwrite} = 4'hf;
        {psel, penable, pwrite} = 3'h0;
        {ehard, esoft, wdog, bmon, tap, tdrv} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        cfg = 14'h2a5c;
        hrcw = 32'h0f0f0f0f;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3000) @(posedge clk);
        chk("core after power-on", core, 1'b0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", r, 32'h01);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl", r, 32'h3);
        apb(1'b0, OFF_CFG, 32'h0);
        chk("straps", r, 32'h2a5c);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", e, 1'b1);
        cfg <= 14'h15a3;
        hrcw <= 32'h1234abcd;
        fire(0, 6'h02);
        chk("config word", phrcw, 32'h1234abcd);
        chk("straps kept", pcfg, 14'h2a5c);
        apb(1'b0, OFF_HRCW, 32'h0);
        chk("config word reg", r, 32'h1234abcd);
        apb(1'b0, OFF_PHASE, 32'h0);
        chk("phase idle", r, 32'h0);
        apb(1'b1, OFF_STATUS, 32'h3f);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status cleared", r, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h2);
        wdog <= 1'b1;
        repeat (10) @(posedge clk);
        wdog <= 1'b0;
        chk("masked watchdog", core, 1'b0);
        apb(1'b1, OFF_CTRL, 32'h3);
        fire(2, 6'h08);
        fire(3, 6'h10);
        hrcw <= 32'h5a5a0001;
        fire(1, 6'h04);
        chk("word kept", phrcw, 32'h1234abcd);
        fire(4, 6'h20);
        fire(5, 6'h20);
        fire(6, 6'h08);
        summarize();
    end
endmodule // test_msrc_top

// ---- rtl/msrc_pkg.sv ----
// Function
// - six sources select three reset actions: power-on, hard, soft
// - status register records latest reset cause
// - power-on resets everything, drives both pins
// - boot straps latched only at power-on
// - soft reset asserted whenever hard is
// - reset pins open-drain, pull low only
// - hard reset drives pins, reloads config word
// - external soft pin ignored while resetting
// - soft reset keeps configuration, resets cores
// - enabled watchdog expiry starts hard sequence
// - enabled bus monitor expiry starts hard sequence
// - test-port command starts soft sequence
// - strap sampling and pll reset power-on only
// - hard pin and unit registers: por, hard
// - every source resets bus, cores, peripherals
// - straps sampled at power-on pin release
// - internal power-on ends 1024 cycles later
// - after lock: hard 512, soft 515 cycles
package msrc_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int POR_DELAY_NS = 51200;
    localparam int HARD_REL_NS = 25600;
    localparam int SOFT_REL_NS = 25750;
    localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
    localparam int HARD_REL_CYC = HARD_REL_NS / CLK_PERIOD_NS;
    localparam int SOFT_REL_CYC = SOFT_REL_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 11;
    localparam int CFG_W = 14;
    localparam int HRCW_W = 32;
    localparam int CAUSE_W = 6;
    // register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam logic [7:0] OFF_HRCW = 8'h0c;
    localparam logic [7:0] OFF_PHASE = 8'h10;
    // status bit positions
    localparam int ST_POR = 0;
    localparam int ST_HARD = 1;
    localparam int ST_SOFT = 2;
    localparam int ST_WDOG = 3;
    localparam int ST_BMON = 4;
    localparam int ST_TAP = 5;
    // control bit positions
    localparam int CT_WDOG_EN = 0;
    localparam int CT_BMON_EN = 1;
    // reset values
    localparam logic [CAUSE_W-1:0] STATUS_RST = 6'h01;
    localparam logic [1:0] CTRL_RST = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_POR_PIN = 3'b001,
        ST_POR_DLY = 3'b010,
        ST_LOCK_WAIT = 3'b011,
        ST_HARD_SEQ = 3'b100,
        ST_SOFT_SEQ = 3'b101,
        ST_REL_WAIT = 3'b110
    } msrc_state_t;
endpackage

// ---- rtl/msrc_top.sv ----
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module msrc_top
    import msrc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // reset pins
    input wire logic i_power_on_reset_n,
    input wire logic i_hard_reset_n,
    output logic o_hard_reset_n,
    output logic o_hard_reset_n_oe,
    input wire logic i_soft_reset_n,
    output logic o_soft_reset_n,
    output logic o_soft_reset_n_oe,
    // internal sources
    input wire logic i_wdog_expired,
    input wire logic i_bmon_expired,
    input wire logic i_tap_reset_cmd,
    input wire logic i_tap_drive_pin,
    input wire logic i_system_pll_lock,
    // configuration
    input wire logic [CFG_W-1:0] i_cfg_pins,
    input wire logic [HRCW_W-1:0] i_hrcw,
    output logic [CFG_W-1:0] o_por_cfg,
    output logic [HRCW_W-1:0] o_hrcw,
    // reset outputs
    output logic o_por_internal,
    output logic o_system_pll_rst,
    output logic o_system_integration_unit_rst,
    output logic o_peripheral_bus_rst,
    output logic o_core_rst,
    output logic o_multicore_bus_system_rst
);

    // pin synchronisers, first stage read only by the second
    logic [2:0] pin_raw;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    assign pin_raw = {i_soft_reset_n, i_hard_reset_n, i_power_on_reset_n};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    sync1_ff[g] <= 1'b0;
                    sync2_ff[g] <= 1'b0;
                end else begin
                    sync1_ff[g] <= pin_raw[g];
                    sync2_ff[g] <= sync1_ff[g];
                end
            end
        end
    endgenerate

    logic por_n_s;
    logic hard_n_s;
    logic soft_n_s;
    assign por_n_s = sync2_ff[0];
    assign hard_n_s = sync2_ff[1];
    assign soft_n_s = sync2_ff[2];

    // sequencer state
    msrc_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CAUSE_W-1:0] status_ff, nxt_status;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic [CFG_W-1:0] por_cfg_ff, nxt_por_cfg;
    logic [HRCW_W-1:0] hrcw_ff, nxt_hrcw;
    logic tap_pin_ff, nxt_tap_pin;
    logic hard_drv_ff, nxt_hard_drv;
    logic soft_drv_ff, nxt_soft_drv;
    logic core_rst_ff, nxt_core_rst;
    logic siu_rst_ff, nxt_siu_rst;
    logic pll_rst_ff, nxt_pll_rst;
    logic por_int_ff, nxt_por_int;

    logic wr_status;
    logic wr_ctrl;
    logic wdog_req;
    logic bmon_req;
    logic [CAUSE_W-1:0] cause;

    assign wr_status = i_psel && i_penable && i_pwrite &&
        (i_paddr == OFF_STATUS);
    assign wr_ctrl = i_psel && i_penable && i_pwrite && (i_paddr == OFF_CTRL);
    assign wdog_req = i_wdog_expired && ctrl_ff[CT_WDOG_EN];
    assign bmon_req = i_bmon_expired && ctrl_ff[CT_BMON_EN];

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_por_cfg = por_cfg_ff;
        nxt_hrcw = hrcw_ff;
        nxt_tap_pin = tap_pin_ff;
        cause = '0;
        unique case (state_ff)
            ST_IDLE: begin
                // hard sources outrank soft ones
                if (!hard_n_s || wdog_req || bmon_req) begin
                    cause[ST_HARD] = !hard_n_s;
                    cause[ST_WDOG] = wdog_req;
                    cause[ST_BMON] = bmon_req;
                    nxt_state = ST_HARD_SEQ;
                    nxt_cnt = '0;
                    nxt_hrcw = i_hrcw;
                end else if (!soft_n_s || i_tap_reset_cmd) begin
                    cause[ST_SOFT] = !soft_n_s;
                    cause[ST_TAP] = i_tap_reset_cmd;
                    nxt_tap_pin = soft_n_s ? i_tap_drive_pin : 1'b1;
                    nxt_state = ST_SOFT_SEQ;
                    nxt_cnt = '0;
                end
            end
            ST_POR_PIN: begin
                if (por_n_s) begin
                    nxt_por_cfg = i_cfg_pins;
                    nxt_state = ST_POR_DLY;
                    nxt_cnt = '0;
                end
            end
            ST_POR_DLY: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CNT_W'(POR_DELAY_CYC - 1)) begin
                    nxt_state = ST_LOCK_WAIT;
                    nxt_cnt = '0;
                end
            end
            ST_LOCK_WAIT: begin
                if (i_system_pll_lock) begin
                    nxt_hrcw = i_hrcw;
                    nxt_state = ST_HARD_SEQ;
                    nxt_cnt = '0;
                end
            end
            ST_HARD_SEQ: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CNT_W'(SOFT_REL_CYC - 1)) begin
                    nxt_state = ST_REL_WAIT;
                end
            end
            ST_SOFT_SEQ: begin
                // a hard request may still escalate a running soft one
                if (!hard_n_s || wdog_req || bmon_req) begin
                    cause[ST_HARD] = !hard_n_s;
                    cause[ST_WDOG] = wdog_req;
                    cause[ST_BMON] = bmon_req;
                    nxt_state = ST_HARD_SEQ;
                    nxt_cnt = '0;
                    nxt_hrcw = i_hrcw;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == CNT_W'(SOFT_REL_CYC - 1)) begin
                        nxt_state = ST_REL_WAIT;
                    end
                end
            end
            ST_REL_WAIT: begin
                // our own drive takes two cycles to clear the synchroniser
                if (hard_n_s && soft_n_s) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_POR_PIN;
                nxt_cnt = '0;
            end
        endcase
        // power-on pin wins over every state
        if (!por_n_s) begin
            cause = '0;
            cause[ST_POR] = 1'b1;
            nxt_state = ST_POR_PIN;
            nxt_cnt = '0;
        end
        // new cause replaces the record, beating a software clear
        if ((state_ff != ST_POR_PIN || cause != 6'h01) && cause != '0) begin
            nxt_status = cause;
        end else begin
            nxt_status = status_ff;
            if (wr_status) begin
                nxt_status = status_ff & ~i_pwdata[CAUSE_W-1:0];
            end
        end
        nxt_ctrl = wr_ctrl ? i_pwdata[1:0] : ctrl_ff;
        if (siu_rst_ff) begin
            nxt_ctrl = CTRL_RST;
        end
    end

    // reset outputs, all changes land on a clock edge
    always_comb begin
        nxt_pll_rst = (nxt_state == ST_POR_PIN) ||
            (nxt_state == ST_POR_DLY);
        nxt_por_int = nxt_pll_rst;
        nxt_hard_drv = nxt_pll_rst || (nxt_state == ST_LOCK_WAIT) ||
            ((nxt_state == ST_HARD_SEQ) &&
             (nxt_cnt < CNT_W'(HARD_REL_CYC)));
        nxt_siu_rst = nxt_pll_rst || (nxt_state == ST_LOCK_WAIT) ||
            (nxt_state == ST_HARD_SEQ);
        nxt_core_rst = nxt_siu_rst ||
            (nxt_state == ST_SOFT_SEQ);
        nxt_soft_drv = nxt_siu_rst || ((nxt_state == ST_SOFT_SEQ) &&
            nxt_tap_pin);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_POR_PIN;
            cnt_ff <= '0;
            status_ff <= STATUS_RST;
            ctrl_ff <= CTRL_RST;
            por_cfg_ff <= '0;
            hrcw_ff <= '0;
            tap_pin_ff <= 1'b1;
            hard_drv_ff <= 1'b1;
            soft_drv_ff <= 1'b1;
            core_rst_ff <= 1'b1;
            siu_rst_ff <= 1'b1;
            pll_rst_ff <= 1'b1;
            por_int_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            status_ff <= nxt_status;
            ctrl_ff <= nxt_ctrl;
            por_cfg_ff <= nxt_por_cfg;
            hrcw_ff <= nxt_hrcw;
            tap_pin_ff <= nxt_tap_pin;
            hard_drv_ff <= nxt_hard_drv;
            soft_drv_ff <= nxt_soft_drv;
            core_rst_ff <= nxt_core_rst;
            siu_rst_ff <= nxt_siu_rst;
            pll_rst_ff <= nxt_pll_rst;
            por_int_ff <= nxt_por_int;
        end
    end

    // open-drain: value is always low, only the enable moves
    assign o_hard_reset_n = 1'b0;
    assign o_hard_reset_n_oe = hard_drv_ff;
    assign o_soft_reset_n = 1'b0;
    assign o_soft_reset_n_oe = soft_drv_ff;
    assign o_por_cfg = por_cfg_ff;
    assign o_hrcw = hrcw_ff;
    assign o_por_internal = por_int_ff;
    assign o_system_pll_rst = pll_rst_ff;
    assign o_system_integration_unit_rst = siu_rst_ff;
    assign o_peripheral_bus_rst = core_rst_ff;
    assign o_core_rst = core_rst_ff;
    assign o_multicore_bus_system_rst = core_rst_ff;

    // apb read path, sampled in setup so access needs no wait state
    logic [31:0] prdata_ff, nxt_prdata;
    logic pslverr_ff, nxt_pslverr;

    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (i_psel && !i_penable) begin
            nxt_pslverr = 1'b0;
            nxt_prdata = '0;
            unique case (i_paddr)
                OFF_STATUS: nxt_prdata = {26'h0, status_ff};
                OFF_CTRL: nxt_prdata = {30'h0, ctrl_ff};
                OFF_CFG: nxt_prdata = {18'h0, por_cfg_ff};
                OFF_HRCW: nxt_prdata = hrcw_ff;
                OFF_PHASE: nxt_prdata = {29'h0, state_ff};
                default: nxt_pslverr = 1'b1;
            endcase
            if (i_pwrite) begin
                nxt_prdata = '0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign o_pready = i_psel && i_penable;
    assign o_prdata = prdata_ff;
    assign o_pslverr = pslverr_ff && i_psel && i_penable;

endmodule // msrc_top
